/* design/lre_consts.svh */
// Purpose: Named offsets, fields, reset values and timing for the lamp register bank
// Assumes: 20 MHz system clock
// Notes:   Definitions only
`ifndef LRE_CONSTS_SVH
`define LRE_CONSTS_SVH

`define LRE_ADDR_LAMP_LEVEL   8'h05
`define LRE_ADDR_LAMP_TIMING  8'h07
`define LRE_ADDR_OUT_SELECT   8'h09
`define LRE_RESET_VALUE       8'h00
`define LRE_READ_UNMAPPED     8'h00
`define LRE_LAMP_LEVEL_MASK   8'h7f

`define LRE_BIT_BLINK_ON      6
`define LRE_BIT_RAMP_ON       5
`define LRE_LEVEL_MSB         4
`define LRE_DARK_MSB          7
`define LRE_DARK_LSB          6
`define LRE_LIT_MSB           5
`define LRE_LIT_LSB           4
`define LRE_RISE_MSB          3
`define LRE_RISE_LSB          2
`define LRE_FALL_MSB          1
`define LRE_FALL_LSB          0
`define LRE_SEL_MSB           7
`define LRE_SEL_LSB           6
`define LRE_TORCH_MSB         5
`define LRE_TORCH_LSB         3
`define LRE_STROBE_MSB        2
`define LRE_STROBE_LSB        0

// Lamp current in 0.5 mA units
`define LRE_LEVEL_GAP_CODE    5'h1d
`define LRE_LEVEL_TOP_CODE    5'h1f
`define LRE_LEVEL_15MA_CODE   5'h1e
`define LRE_LEVEL_15MA        6'h1e
`define LRE_LEVEL_16MA        6'h20
`define LRE_LEVEL_ZERO        6'h00

// Phase times: base 512 ms dark, 128 ms lit and ramp, doubled per code step
`define LRE_DARK_BASE_MS      512
`define LRE_LIT_BASE_MS       128
`define LRE_RAMP_BASE_MS      128
`define LRE_DARK_BASE_LOG2    4'h9
`define LRE_LIT_BASE_LOG2     4'h7
`define LRE_RAMP_BASE_LOG2    4'h7
`define LRE_RAMP_STEPS_LOG2   4'h5
`define LRE_RAMP_FULL         6'h20
`define LRE_CLK_PERIOD_NS     50
`define LRE_MS_NS             1000000
`define LRE_MS_CYCLES         (`LRE_MS_NS / `LRE_CLK_PERIOD_NS)

`endif

/* design/lre_lamp_if.sv */
// Purpose: Carries lamp settings to the sequencer and its drive level back
// Assumes: One clock domain
// Notes:   cfg side is the register bank, seq side the sequencer
`timescale 1ns/100ps
interface lre_lamp_if;
  logic       enable;
  logic       blink_on;
  logic       ramp_on;
  logic [5:0] target;
  logic [1:0] dark_time;
  logic [1:0] lit_time;
  logic [1:0] rise_time;
  logic [1:0] fall_time;
  logic [5:0] level;

  modport cfg (output enable, blink_on, ramp_on, target, dark_time, lit_time, rise_time,
               fall_time, input level);
  modport seq (input enable, blink_on, ramp_on, target, dark_time, lit_time, rise_time,
               fall_time, output level);
endinterface

/* design/lre_lamp_regs.sv */
// Purpose: Status lamp and channel enable register bank with output decode
// Assumes: Register port from the serial host core, one write or read per cycle
// Notes:   Strobe and torch level registers live outside; their values arrive as inputs
`timescale 1ns/100ps
`include "lre_consts.svh"
module lre_lamp_regs
  import lre_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `LRE_MS_CYCLES
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       gate_pin_in,
  input  wire logic [4:0] strobe_level_ch1_in,
  input  wire logic [4:0] strobe_level_ch2_in,
  input  wire logic [2:0] torch_level_ch1_in,
  input  wire logic [2:0] torch_level_ch2_in,
  output logic      [7:0] reg_rdata_out,
  output logic      [5:0] status_lamp_out,
  output logic            channel_one_strobe_out,
  output logic            channel_one_torch_out,
  output logic      [4:0] channel_one_out,
  output logic            channel_two_strobe_out,
  output logic            channel_two_torch_out,
  output logic      [4:0] channel_two_out
);
  logic [7:0] lamp_level_reg;
  logic [7:0] lamp_timing_reg;
  logic [7:0] out_select_reg;

  lre_lamp_if lamp_bus ();

  // Address decode for writes and read data select
  wire       hit_level   = (reg_addr_in == `LRE_ADDR_LAMP_LEVEL);
  wire       hit_timing  = (reg_addr_in == `LRE_ADDR_LAMP_TIMING);
  wire       hit_select  = (reg_addr_in == `LRE_ADDR_OUT_SELECT);
  wire [7:0] rdata_next  = hit_level  ? lamp_level_reg :
                           hit_timing ? lamp_timing_reg :
                           hit_select ? out_select_reg : `LRE_READ_UNMAPPED;

  // Lamp current code to 0.5 mA units; the top codes leave the line,
  // and the unlisted gap code is taken as 15.0 mA like its neighbour
  wire [4:0] level_code  = lamp_level_reg[`LRE_LEVEL_MSB:0];
  wire       top_flat    = (level_code == `LRE_LEVEL_15MA_CODE) ||
                           (level_code == `LRE_LEVEL_GAP_CODE);
  wire [5:0] level_units = (level_code == `LRE_LEVEL_TOP_CODE) ? `LRE_LEVEL_16MA :
                           top_flat ? `LRE_LEVEL_15MA :
                           6'(level_code) + 6'h01;

  wire [1:0] lamp_sel    = out_select_reg[`LRE_SEL_MSB:`LRE_SEL_LSB];
  wire [2:0] torch_sel   = out_select_reg[`LRE_TORCH_MSB:`LRE_TORCH_LSB];
  wire [2:0] strobe_sel  = out_select_reg[`LRE_STROBE_MSB:`LRE_STROBE_LSB];
  // Bit 1 of the select is the enable, bit 0 chooses the gate pin
  wire       lamp_on     = lamp_sel[1] && (!lamp_sel[0] || gate_pin_in);

  // Code bit 2 means gated; bits 1:0 pick the channels, 100 picks none
  wire [1:0] torch_on    = torch_sel[1:0] & {2{!torch_sel[2] || gate_pin_in}};
  wire [1:0] strobe_on   = strobe_sel[1:0] & {2{!strobe_sel[2] || gate_pin_in}};

  // Strobe overrides torch on a shared channel
  wire [4:0] ch1_level   = strobe_on[0] ? strobe_level_ch1_in :
                           torch_on[0]  ? 5'(torch_level_ch1_in) : 5'h00;
  wire [4:0] ch2_level   = strobe_on[1] ? strobe_level_ch2_in :
                           torch_on[1]  ? 5'(torch_level_ch2_in) : 5'h00;

  assign lamp_bus.enable    = lamp_on;
  assign lamp_bus.blink_on  = lamp_level_reg[`LRE_BIT_BLINK_ON];
  assign lamp_bus.ramp_on   = lamp_level_reg[`LRE_BIT_RAMP_ON];
  assign lamp_bus.target    = level_units;
  assign lamp_bus.dark_time = lamp_timing_reg[`LRE_DARK_MSB:`LRE_DARK_LSB];
  assign lamp_bus.lit_time  = lamp_timing_reg[`LRE_LIT_MSB:`LRE_LIT_LSB];
  assign lamp_bus.rise_time = lamp_timing_reg[`LRE_RISE_MSB:`LRE_RISE_LSB];
  assign lamp_bus.fall_time = lamp_timing_reg[`LRE_FALL_MSB:`LRE_FALL_LSB];

  lre_lamp_seq #(
    .MS_CYCLES (MS_CYCLES)
  ) u_seq (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .lamp_in    (lamp_bus)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lamp_level_reg  <= `LRE_RESET_VALUE;
      lamp_timing_reg <= `LRE_RESET_VALUE;
      out_select_reg  <= `LRE_RESET_VALUE;
    end else if (reg_wr_in) begin
      if (hit_level) lamp_level_reg <= reg_wdata_in & `LRE_LAMP_LEVEL_MASK;
      if (hit_timing) lamp_timing_reg <= reg_wdata_in;
      if (hit_select) out_select_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out          <= `LRE_READ_UNMAPPED;
      status_lamp_out        <= `LRE_LEVEL_ZERO;
      channel_one_strobe_out <= 1'b0;
      channel_one_torch_out  <= 1'b0;
      channel_one_out        <= 5'h00;
      channel_two_strobe_out <= 1'b0;
      channel_two_torch_out  <= 1'b0;
      channel_two_out        <= 5'h00;
    end else begin
      reg_rdata_out          <= rdata_next;
      status_lamp_out        <= lamp_bus.level;
      channel_one_strobe_out <= strobe_on[0];
      channel_one_torch_out  <= torch_on[0] && !strobe_on[0];
      channel_one_out        <= ch1_level;
      channel_two_strobe_out <= strobe_on[1];
      channel_two_torch_out  <= torch_on[1] && !strobe_on[1];
      channel_two_out        <= ch2_level;
    end
  end
endmodule

/* design/lre_lamp_seq.sv */
// Purpose: Status lamp blink and ramp sequencer
// Assumes: Enable and settings may change at any cycle
// Notes:   Millisecond base is a free-running divider, so phases may be up to 1 ms short
`timescale 1ns/100ps
`include "lre_consts.svh"
module lre_lamp_seq
  import lre_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `LRE_MS_CYCLES
) (
  input  wire logic   clk_sys_in,
  input  wire logic   rst_n_in,
  lre_lamp_if.seq     lamp_in
);
  logic [14:0] ms_cnt_reg;
  logic [12:0] elapsed_reg;
  lre_phase_t  phase_reg;
  lre_phase_t  phase_next;
  logic [5:0]  level_reg;
  logic [5:0]  level_next;

  wire         ms_tick    = (ms_cnt_reg == 15'(MS_CYCLES - 1));
  wire  [1:0]  ramp_code  = (phase_reg == LRE_PH_FALL) ? lamp_in.fall_time
                                                       : lamp_in.rise_time;
  wire  [3:0]  dur_log2   = (phase_reg == LRE_PH_DARK) ? `LRE_DARK_BASE_LOG2 + 4'(lamp_in.dark_time) :
                            (phase_reg == LRE_PH_LIT)  ? `LRE_LIT_BASE_LOG2 + 4'(lamp_in.lit_time) :
                                                         `LRE_RAMP_BASE_LOG2 + 4'(ramp_code);
  wire  [12:0] dur_last   = (13'h0001 << dur_log2) - 13'h0001;
  wire         phase_done = ms_tick && (elapsed_reg == dur_last);
  // Ramp progress in 1/32 steps of the chosen ramp time
  wire  [5:0]  rise_frac  = 6'(elapsed_reg >> (dur_log2 - `LRE_RAMP_STEPS_LOG2));
  wire  [5:0]  frac       = (phase_reg == LRE_PH_FALL) ? `LRE_RAMP_FULL - rise_frac : rise_frac;
  wire  [11:0] scaled     = lamp_in.target * frac;
  wire  [5:0]  ramp_level = 6'(scaled >> `LRE_RAMP_STEPS_LOG2);
  wire         lit_entry_ramp = lamp_in.ramp_on;

  always_comb begin
    phase_next = phase_reg;
    if (!lamp_in.enable) begin
      phase_next = LRE_PH_OFF;
    end else begin
      unique case (phase_reg)
        LRE_PH_OFF:  phase_next = lit_entry_ramp ? LRE_PH_RISE : LRE_PH_LIT;
        LRE_PH_RISE: if (phase_done || !lamp_in.ramp_on) phase_next = LRE_PH_LIT;
        LRE_PH_LIT:  if (lamp_in.blink_on && phase_done) begin
          phase_next = lamp_in.ramp_on ? LRE_PH_FALL : LRE_PH_DARK;
        end
        LRE_PH_FALL: if (phase_done || !lamp_in.ramp_on) phase_next = LRE_PH_DARK;
        LRE_PH_DARK: if (phase_done || !lamp_in.blink_on) begin
          phase_next = lamp_in.ramp_on ? LRE_PH_RISE : LRE_PH_LIT;
        end
        default:     phase_next = LRE_PH_OFF;
      endcase
    end
  end

  always_comb begin
    unique case (phase_reg)
      LRE_PH_LIT:               level_next = lamp_in.target;
      LRE_PH_RISE, LRE_PH_FALL: level_next = ramp_level;
      default:                  level_next = `LRE_LEVEL_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ms_cnt_reg  <= 15'h0000;
      elapsed_reg <= 13'h0000;
      phase_reg   <= LRE_PH_OFF;
      level_reg   <= `LRE_LEVEL_ZERO;
    end else begin
      ms_cnt_reg  <= ms_tick ? 15'h0000 : ms_cnt_reg + 15'h0001;
      // Elapsed restarts on every phase change
      elapsed_reg <= (phase_next != phase_reg) ? 13'h0000 :
                     ms_tick ? elapsed_reg + 13'h0001 : elapsed_reg;
      phase_reg   <= phase_next;
      level_reg   <= level_next;
    end
  end

  assign lamp_in.level = level_reg;
endmodule

/* design/lre_pkg.sv */
// Purpose: Types shared by the lamp register bank modules
// Assumes: lre_consts.svh holds all numbers
// Notes:   Types only
package lre_pkg;
  typedef enum logic [2:0] {
    LRE_PH_OFF  = 3'b000,
    LRE_PH_RISE = 3'b001,
    LRE_PH_LIT  = 3'b010,
    LRE_PH_FALL = 3'b011,
    LRE_PH_DARK = 3'b100
  } lre_phase_t;
endpackage

/* sim/lre_host_model.sv */
// Purpose: Serial host stand-in driving the register port
// Assumes: Requests change just after a rising edge
// Notes:   Write data is inverted once released
`timescale 1ns/100ps
module lre_host_model (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out = 8'h00,
  output logic      [7:0] reg_wdata_out = 8'h00,
  output logic            reg_wr_out = 1'b0
);
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    d = reg_rdata_in;
  endtask
endmodule

/* sim/lre_lamp_monitor.sv */
// Purpose: Port checker for the lamp register bank
// Assumes: Shadow copies of written registers track the bank
// Notes:   Decode is checked once inputs have been quiet 15 cycles
`timescale 1ns/100ps
module lre_lamp_monitor #(
  parameter int unsigned MS_CYCLES = 4
) (
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       gate_pin_in,
  input wire logic [4:0] strobe_level_ch1_in,
  input wire logic [4:0] strobe_level_ch2_in,
  input wire logic [2:0] torch_level_ch1_in,
  input wire logic [2:0] torch_level_ch2_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [5:0] status_lamp_out,
  input wire logic       channel_one_strobe_out,
  input wire logic       channel_one_torch_out,
  input wire logic [4:0] channel_one_out,
  input wire logic       channel_two_strobe_out,
  input wire logic       channel_two_torch_out,
  input wire logic [4:0] channel_two_out
);
  logic [7:0]  lvl_reg, sel_reg;
  logic [16:0] in_reg;
  logic [3:0]  cnt_reg;
  wire  [16:0] ins = {gate_pin_in, strobe_level_ch1_in, strobe_level_ch2_in,
                      torch_level_ch1_in, torch_level_ch2_in};
  wire         wr_lvl = reg_wr_in && reg_addr_in == 8'h05;
  wire         wr_sel = reg_wr_in && reg_addr_in == 8'h09;
  wire         g = gate_pin_in;
  wire  [2:0]  sc = sel_reg[2:0];
  wire  [2:0]  tc = sel_reg[5:3];
  wire         s1 = sc == 3'b001 || sc == 3'b011 || (g && (sc == 3'b101 || sc == 3'b111));
  wire         s2 = sc == 3'b010 || sc == 3'b011 || (g && (sc == 3'b110 || sc == 3'b111));
  wire         t1 = tc == 3'b001 || tc == 3'b011 || (g && (tc == 3'b101 || tc == 3'b111));
  wire         t2 = tc == 3'b010 || tc == 3'b011 || (g && (tc == 3'b110 || tc == 3'b111));
  wire         lamp_on = sel_reg[7] && (!sel_reg[6] || g);
  wire  [5:0]  tgt = lvl_reg[4:0] inside {5'h1d, 5'h1e} ? 6'h1e :
                     lvl_reg[4:0] == 5'h1f ? 6'h20 :
                     {1'b0, lvl_reg[4:0]} + 6'h01;
  wire         ok = cnt_reg == 4'hf;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lvl_reg <= 8'h00;
      sel_reg <= 8'h00;
      in_reg  <= 17'h00000;
      cnt_reg <= 4'h0;
    end else begin
      if (wr_lvl) lvl_reg <= reg_wdata_in;
      if (wr_sel) sel_reg <= reg_wdata_in;
      in_reg  <= ins;
      cnt_reg <= (wr_lvl || wr_sel || ins != in_reg) ? 4'h0 : ok ? cnt_reg : cnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Read data is registered from the register, so a write shows two edges later
  sequence wr_at(logic [7:0] a);
    reg_wr_in && reg_addr_in == a ##1 !reg_wr_in && reg_addr_in == a;
  endsequence
  level_readback_a: assert property (wr_at(8'h05) |=>
    reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h7f)) else $error("level readback wrong");
  timing_readback_a: assert property (wr_at(8'h07) |=>
    reg_rdata_out == $past(reg_wdata_in, 2)) else $error("timing readback wrong");
  select_readback_a: assert property (wr_at(8'h09) |=>
    reg_rdata_out == $past(reg_wdata_in, 2)) else $error("select readback wrong");
  unmapped_read_a: assert property (!(reg_addr_in inside {8'h05, 8'h07, 8'h09}) |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  strobe_decode_a: assert property (ok |-> channel_one_strobe_out == s1 &&
    channel_two_strobe_out == s2) else $error("strobe enable wrong");
  torch_decode_a: assert property (ok |-> channel_one_torch_out == (t1 && !s1) &&
    channel_two_torch_out == (t2 && !s2)) else $error("torch enable wrong");
  channel_level_a: assert property (ok |->
    channel_one_out == (s1 ? strobe_level_ch1_in : t1 ? {2'b00, torch_level_ch1_in} : 5'h00) &&
    channel_two_out == (s2 ? strobe_level_ch2_in : t2 ? {2'b00, torch_level_ch2_in} : 5'h00))
    else $error("channel level wrong");
  lamp_level_a: assert property (ok && (!lamp_on || lvl_reg[6:5] == 2'b00) |->
    status_lamp_out == (lamp_on ? tgt : 6'h00)) else $error("lamp level wrong");
endmodule
bind lre_lamp_regs lre_lamp_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (.clk_sys_in, .rst_n_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .gate_pin_in, .strobe_level_ch1_in,
  .strobe_level_ch2_in, .torch_level_ch1_in, .torch_level_ch2_in, .reg_rdata_out,
  .status_lamp_out, .channel_one_strobe_out, .channel_one_torch_out, .channel_one_out,
  .channel_two_strobe_out, .channel_two_torch_out, .channel_two_out);

/* sim/testbench.sv */
// Purpose: Self-checking bench for the lamp register bank
// Assumes: One millisecond is 4 cycles in this run
// Notes:   Strobe and torch levels are fixed for all rows
`timescale 1ns/100ps
module testbench;
  logic       clk_sys_in = 1'b0, rst_n_in = 1'b0, gate_pin_in = 1'b0;
  logic [4:0] s1 = 5'h11, s2 = 5'h0a;
  logic [2:0] t1 = 3'h5, t2 = 3'h3;
  logic [7:0] addr, wdata, rdata, rd;
  logic       wr, c1s, c1t, c2s, c2t;
  logic [4:0] c1o, c2o;
  logic [5:0] lamp;
  int         n_fail = 0, comparisons = 0, n;
  logic [7:0] adr [3] = '{8'h05, 8'h07, 8'h09};
  // Select, gate, then lamp level, channel one and channel two
  logic [28:0] rows [13] = '{{8'hc0, 1'b1, 20'h78000}, {8'h4a, 1'b0, 20'h012ca},
    {8'h91, 1'b0, 20'h7a8a3}, {8'hd8, 1'b0, 20'h012a3}, {8'h03, 1'b0, 20'h028ca},
    {8'h9b, 1'b1, 20'h7a8ca}, {8'h64, 1'b1, 20'h00000}, {8'hee, 1'b1, 20'h792ca},
    {8'hee, 1'b0, 20'h00000}, {8'h35, 1'b1, 20'h028a3}, {8'h3f, 1'b1, 20'h028ca},
    {8'h3f, 1'b0, 20'h00000}, {8'hb8, 1'b1, 20'h792a3}};
  always #25 clk_sys_in = ~clk_sys_in;
  lre_host_model host_u (.clk_sys_in, .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr));
  lre_lamp_regs #(.MS_CYCLES(4)) dut_u (.clk_sys_in, .rst_n_in, .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .gate_pin_in, .strobe_level_ch1_in(s1),
    .strobe_level_ch2_in(s2), .torch_level_ch1_in(t1), .torch_level_ch2_in(t2),
    .reg_rdata_out(rdata), .status_lamp_out(lamp), .channel_one_strobe_out(c1s),
    .channel_one_torch_out(c1t), .channel_one_out(c1o), .channel_two_strobe_out(c2s),
    .channel_two_torch_out(c2t), .channel_two_out(c2o));
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic count(input logic lit, output int k);
    k = 0;
    while ((lamp != 6'h00) == lit && k < 5000) begin
      @(negedge clk_sys_in);
      k++;
    end
  endtask
  initial begin
    #(20000 * 50);
    $display("watchdog expired");
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    check({lamp, c1s, c1t, c1o, c2s, c2t, c2o}, 20'h0);
    foreach (adr[i]) begin
      host_u.read(adr[i], rd);
      check(20'(rd), 20'h0);
    end
    host_u.write(8'h05, 8'hff);
    host_u.read(8'h05, rd);
    check(20'(rd), 20'h7f);
    host_u.write(8'h07, 8'ha5);
    host_u.read(8'h07, rd);
    check(20'(rd), 20'ha5);
    host_u.write(8'h06, 8'h5a);
    host_u.read(8'h06, rd);
    check(20'(rd), 20'h0);
    host_u.write(8'h05, 8'h1d);
    $display("reset and readback done");
    foreach (rows[i]) begin
      host_u.write(8'h09, rows[i][28:21]);
      gate_pin_in <= rows[i][20];
      repeat (20) @(negedge clk_sys_in);
      check({lamp, c1s, c1t, c1o, c2s, c2t, c2o}, rows[i][19:0]);
    end
    host_u.write(8'h09, 8'h03);
    s1 <= 5'h1f;
    repeat (4) @(negedge clk_sys_in);
    check(20'(c1o), 20'h1f);
    $display("decode table done");
    host_u.write(8'h07, 8'h00);
    host_u.write(8'h05, 8'h5e);
    host_u.write(8'h09, 8'h80);
    count(1'b0, n);
    check(20'(lamp), 20'h1e);
    count(1'b1, n);
    check(20'(n >= 508 && n <= 516), 20'h1);
    count(1'b0, n);
    check(20'(n >= 2044 && n <= 2052), 20'h1);
    $display("blink done");
    host_u.write(8'h09, 8'h00);
    host_u.write(8'h05, 8'h3f);
    host_u.write(8'h09, 8'h80);
    count(1'b0, n);
    repeat (256) @(negedge clk_sys_in);
    check(20'(lamp > 6'h00 && lamp < 6'h20), 20'h1);
    repeat (400) @(negedge clk_sys_in);
    check(20'(lamp), 20'h20);
    $display("ramp done");
    // Chained phases start on the divider tick, so their lengths are exact
    host_u.write(8'h09, 8'h00);
    host_u.write(8'h07, 8'h11);
    host_u.write(8'h05, 8'h7f);
    host_u.write(8'h09, 8'h80);
    count(1'b0, n);
    count(1'b1, n);
    check(20'(n >= 2540 && n <= 2548), 20'h1);
    count(1'b0, n);
    check(20'(n >= 2060 && n <= 2068), 20'h1);
    $display("blink with ramp done");
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (2) @(negedge clk_sys_in);
    check({lamp, c1s, c1t, c1o, c2s, c2t, c2o}, 20'h0);
    foreach (adr[i]) begin
      host_u.read(adr[i], rd);
      check(20'(rd), 20'h0);
    end
    $display("mid-run reset done");
    stop_test;
  end
endmodule
